/* File: hw/icrp_regs.sv */
// Interrupt flag, enable, priority and proximity reload registers.
// Assumes src_req comes from logic on aclk and the timer itself lives outside.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module icrp_regs
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [icrp_pkg::AXI_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [icrp_pkg::AXI_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Source requests
   input wire logic [icrp_pkg::NSRC-1:0] src_req,
   // Selected request to vectoring logic
   output logic req_valid,
   output logic [4:0] req_id,
   output logic [2:0] req_prio,
   output logic [1:0] req_sub,
   // Proximity timer
   output logic timer_active,
   output logic timer_load,
   output logic [31:0] timer_reload,
   // Interrupt
   output logic irq
);
   import icrp_pkg::*;

   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [CTRL_SEL_W-1:0] ctrl_sel_q;
   logic [31:0] reload_q;
   logic [NSRC-1:0] flag_q, flag_d, en_q;
   icrp_prio_t prio_q [NSRC];
   icrp_sub_t sub_q [NSRC];
   logic [EV_W-1:0] evstat_q, evstat_d, even_q;
   logic req_valid_q, timer_active_q, timer_load_q, irq_q;
   logic [4:0] req_id_q;
   logic [2:0] req_prio_q;
   logic [1:0] req_sub_q;

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int j = 0; j < 4; j++)
      begin
         if (strb[j])
            r[8*j +: 8] = nw[8*j +: 8];
      end
      return r;
   endfunction

   // Word-aligned address match
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return {a[7:2], 2'b00} == off;
   endfunction

   function automatic logic is_prio(input logic [7:0] a);
      return ({a[7:2], 2'b00} >= OFF_PRIO0) && ({a[7:2], 2'b00} <= OFF_PRIO7);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return {a[7:2], 2'b00} <= OFF_SELECT;
   endfunction

   // Read mux; unused priority bits come back zero
   function automatic logic [31:0] rd_word(input logic [7:0] a);
      logic [31:0] r;
      logic [2:0] k;
      r = RST_WORD;
      k = a[4:2] - OFF_PRIO0[4:2];
      if (hit(a, OFF_CTRL))
         r[CTRL_SEL_LSB +: CTRL_SEL_W] = ctrl_sel_q;
      else if (hit(a, OFF_RELOAD))
         r = reload_q;
      else if (hit(a, OFF_FLAG))
         r = flag_q;
      else if (hit(a, OFF_ENABLE))
         r = en_q;
      else if (is_prio(a))
      begin
         for (int j = 0; j < 4; j++)
         begin
            r[8*j+PRIO_LSB +: 3] = prio_q[{k, 2'(j)}]; // RL8 RL9
            r[8*j+SUB_LSB +: 2] = sub_q[{k, 2'(j)}];
         end
      end
      else if (hit(a, OFF_EVSTAT))
         r[EV_W-1:0] = evstat_q;
      else if (hit(a, OFF_EVEN))
         r[EV_W-1:0] = even_q;
      else if (hit(a, OFF_SELECT))
         r = {req_valid_q, 18'h0, req_id_q, 1'b0, req_prio_q, 2'b0, req_sub_q};
      return r;
   endfunction

   // Write strobes decoded from the held address
   wire aw_hs = awvalid && awready_q;
   wire w_hs = wvalid && wready_q;
   wire wr_fire = !awready_q && !wready_q && !bvalid_q;
   wire ctrl_we = wr_fire && hit(aw_addr_q, OFF_CTRL);
   wire reload_we = wr_fire && hit(aw_addr_q, OFF_RELOAD);
   wire flag_we = wr_fire && hit(aw_addr_q, OFF_FLAG);
   wire en_we = wr_fire && hit(aw_addr_q, OFF_ENABLE);
   wire prio_we = wr_fire && is_prio(aw_addr_q);
   wire evclr_we = wr_fire && hit(aw_addr_q, OFF_EVCLR) && w_strb_q[0];
   wire even_we = wr_fire && hit(aw_addr_q, OFF_EVEN) && w_strb_q[0];
   wire [2:0] prio_k = aw_addr_q[4:2] - OFF_PRIO0[4:2];

   // Events: new request on any source, and a timer reload on an enabled one
   wire [NSRC-1:0] new_req = src_req & ~flag_q;
   wire timer_on = ctrl_sel_q != '0;
   wire timer_trig = timer_on && |(new_req & en_q);
   wire [EV_W-1:0] ev = {timer_trig, |new_req};
   wire [EV_W-1:0] ev_clr = evclr_we ? w_data_q[EV_W-1:0] : '0;

   // Hardware set beats a same-cycle software clear
   assign flag_d = (flag_we ? wmask(flag_q, w_data_q, w_strb_q) : flag_q) | src_req; // RL11 RL3
   assign evstat_d = (evstat_q & ~ev_clr) | ev;

   // AXI write channel: take address and data in any order, answer once both held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         aw_addr_q <= 8'h00;
         w_data_q <= RST_WORD;
         w_strb_q <= 4'h0;
      end
      else
      begin
         if (aw_hs)
         begin
            aw_addr_q <= awaddr;
            awready_q <= 1'b0;
         end
         if (w_hs)
         begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            wready_q <= 1'b0;
         end
         if (wr_fire)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_q && bready)
         begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // AXI read channel: data registered one edge after the address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= RST_WORD;
         rresp_q <= RESP_OKAY;
      end
      else if (arvalid && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_word(araddr);
         rresp_q <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && rready)
      begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // Control, reload, flag, enable and event registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_sel_q <= '0; // RL10
         reload_q <= RST_WORD;
         flag_q <= '0;
         en_q <= '0;
         evstat_q <= '0;
         even_q <= '0;
      end
      else
      begin
         if (ctrl_we && w_strb_q[0])
            ctrl_sel_q <= w_data_q[CTRL_SEL_LSB +: CTRL_SEL_W];
         if (reload_we)
            reload_q <= wmask(reload_q, w_data_q, w_strb_q); // RL1
         flag_q <= flag_d; // RL4
         if (en_we)
            en_q <= wmask(en_q, w_data_q, w_strb_q); // RL4 RL5
         evstat_q <= evstat_d;
         if (even_we)
            even_q <= w_data_q[EV_W-1:0];
      end
   end

   // Per-source priority and subpriority, written by byte lane
   for (genvar i = 0; i < NSRC; i++)
   begin : g_src
      wire we = prio_we && (prio_k == 3'(i / 4)) && w_strb_q[i % 4];
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            prio_q[i] <= '0;
            sub_q[i] <= '0;
         end
         else if (we)
         begin
            prio_q[i] <= w_data_q[8*(i%4)+PRIO_LSB +: 3]; // RL6 RL8 RL9
            sub_q[i] <= w_data_q[8*(i%4)+SUB_LSB +: 2]; // RL7
         end
      end
   end

   // Winner search; strict compare lets the lowest index win a full tie
   logic [4:0] best_key;
   logic [4:0] best_id;
   always_comb
   begin
      best_key = 5'h00;
      best_id = 5'h00;
      for (int i = 0; i < NSRC; i++)
      begin
         if (flag_q[i] && en_q[i] && prio_q[i] != 3'h0 && {prio_q[i], sub_q[i]} > best_key) // RL12 RL5 RL6
         begin
            best_key = {prio_q[i], sub_q[i]}; // RL7
            best_id = 5'(i);
         end
      end
   end

   // Registered outputs toward vectoring, timer and interrupt line
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         req_valid_q <= 1'b0;
         req_id_q <= 5'h00;
         req_prio_q <= 3'h0;
         req_sub_q <= 2'h0;
         timer_active_q <= 1'b0;
         timer_load_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         req_valid_q <= best_key != 5'h00; // RL12
         req_id_q <= best_id;
         req_prio_q <= best_key[4:2];
         req_sub_q <= best_key[1:0];
         timer_active_q <= timer_on; // RL2
         timer_load_q <= timer_trig; // RL1 RL2
         irq_q <= |(evstat_d & even_q);
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign req_valid = req_valid_q;
   assign req_id = req_id_q;
   assign req_prio = req_prio_q;
   assign req_sub = req_sub_q;
   assign timer_active = timer_active_q;
   assign timer_load = timer_load_q;
   assign timer_reload = reload_q;
   assign irq = irq_q;

   // Checks on the register behaviour
   sequence s_flag_full_wr;
      flag_we && w_strb_q == 4'hF;
   endsequence
   sequence s_en_full_wr;
      en_we && w_strb_q == 4'hF;
   endsequence

   a_reload_load: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
      timer_trig |=> timer_load_q && timer_reload == $past(reload_q))
      else $error("reload not presented on timer trigger");
   a_timer_idle: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
      ctrl_sel_q == '0 |=> !timer_load_q && !timer_active_q)
      else $error("proximity timer acted while disabled");
   a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      src_req != '0 |=> (flag_q & $past(src_req)) == $past(src_req))
      else $error("request did not set its flag");
   a_flag_write: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
      s_flag_full_wr |=> flag_q == ($past(w_data_q) | $past(src_req)))
      else $error("flag write not applied");
   a_enable_write: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
      s_en_full_wr |=> en_q == $past(w_data_q))
      else $error("enable write not applied");
   a_prio_rsvd: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
      arvalid && arready_q && is_prio(araddr) |=> (rdata_q & 32'hE0E0E0E0) == 32'h0)
      else $error("priority unused bits read nonzero");
   a_select_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
      req_valid_q |-> req_prio_q != 3'h0 && |($past(flag_q & en_q) & (32'h0000_0001 << req_id_q)))
      else $error("forwarded request not flagged and enabled");
   a_disable_blocks: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
      (flag_q & en_q) == '0 |=> !req_valid_q)
      else $error("request forwarded with nothing enabled");
   a_reset_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
      !$past(aresetn) |-> reload_q == RST_WORD && flag_q == '0 && en_q == '0 && !req_valid_q)
      else $error("registers not zero after reset");
endmodule
`default_nettype wire

/* File: hw/icrp_pkg.sv */
// Constants for the interrupt flag, enable and priority register block.
// Assumes one 125 MHz clock and an AXI4-Lite master with 32-bit data.
// Functional notes
// RL1 - Hold a 32-bit reload value, loaded into proximity timer on interrupt events.
// RL2 - Proximity timer stays inactive while its control select field is zero.
// RL3 - Each source flag reads one after a request, zero otherwise.
// RL4 - Flag and enable banks are 32-bit, one bit per source, all read/write.
// RL5 - Enable one lets a source through; zero blocks it from the processor.
// RL6 - Three-bit priority gives levels 1 to 7; zero disables the source.
// RL7 - Two-bit subpriority orders sources within one priority level.
// RL8 - Priority registers hold four sources, priority bits 4:2, subpriority 1:0 per byte.
// RL9 - Top three bits of each priority byte ignore writes and read zero.
// RL10 - All implemented register bits clear to zero at reset.
// RL11 - Hardware sets flags on request; software clears them by writing zero.
// RL12 - Forward only flagged, enabled, nonzero-priority sources; priority then subpriority.
package icrp_pkg;
   localparam int NSRC = 32;
   localparam int AXI_AW = 8;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_RELOAD = 8'h04;
   localparam logic [7:0] OFF_FLAG = 8'h08;
   localparam logic [7:0] OFF_ENABLE = 8'h0C;
   localparam logic [7:0] OFF_PRIO0 = 8'h10;
   localparam logic [7:0] OFF_PRIO7 = 8'h2C;
   localparam logic [7:0] OFF_EVSTAT = 8'h30;
   localparam logic [7:0] OFF_EVCLR = 8'h34;
   localparam logic [7:0] OFF_EVEN = 8'h38;
   localparam logic [7:0] OFF_SELECT = 8'h3C;
   // Field layout
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_SEL_W = 3;
   localparam int PRIO_LSB = 2;
   localparam int SUB_LSB = 0;
   localparam logic [7:0] PRIO_BYTE_MASK = 8'h1F;
   localparam int EV_REQ = 0;
   localparam int EV_TMR = 1;
   localparam int EV_W = 2;
   // Reset values and responses
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef logic [2:0] icrp_prio_t;
   typedef logic [1:0] icrp_sub_t;
endpackage

/* File: testbench/icrp_src_model.sv */
// Far-side model: the interrupt sources feeding the register block.
// Assumes the bench asks for one burst of requests at a time with fire.
`timescale 1ns/1ps
`default_nettype none
module icrp_src_model
(
   // Clock and command from the bench
   input wire logic aclk,
   input wire logic fire,
   input wire logic [31:0] fire_mask,
   // Request levels to the block
   output logic [31:0] src_req
);
   // One-cycle burst; sources fall back low so a flag can only come from a real edge
   always_ff @(posedge aclk)
      src_req <= fire ? fire_mask : 32'h0000_0000;
endmodule
`default_nettype wire

/* File: testbench/tb_irq_flag_enable_priority_regs.sv */
// Self-checking bench for the flag, enable, priority and reload registers.
// Assumes icrp_pkg, the register block and the source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_irq_flag_enable_priority_regs;
   import icrp_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire;
   logic awready, wready, bvalid, arready, rvalid, req_valid, timer_active, timer_load, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, fire_mask, src_req, timer_reload;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, req_sub, resp;
   logic [4:0] req_id;
   logic [2:0] req_prio;
   int fail_count, samples_checked, load_seen;

   // Clock at 125 MHz
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Design and far-side sources; protection bits carry no meaning here
   icrp_regs uut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .src_req, .req_valid, .req_id, .req_prio, .req_sub, .timer_active,
      .timer_load, .timer_reload, .irq);
   icrp_src_model src (.aclk, .fire, .fire_mask, .src_req);

   // Load pulses are one cycle wide, so count them at every edge
   always @(posedge aclk)
      if (timer_load === 1'b1) load_seen++;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (!bvalid);
      // Response ready stays high between writes, so back-to-back calls never toggle it in one step
      resp = bresp;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      while (!rvalid);
      resp = rresp;
      chk(rdata, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Fire one burst, then let flags and selection settle
   task automatic pulse(input logic [31:0] m);
      fire_mask <= m;
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      tick(4);
   endtask

   task automatic t_reset();
      rd(OFF_RELOAD, RST_WORD);
      rd(OFF_FLAG, RST_WORD);
      rd(OFF_ENABLE, RST_WORD);
      rd(OFF_PRIO0, RST_WORD);
      rd(OFF_PRIO7, RST_WORD);
      chk(32'(timer_active), 32'h0000_0000);
   endtask

   task automatic t_reload();
      wr(OFF_RELOAD, 32'hA5C3_0F96, 4'hF);
      chk(32'(resp), 32'(RESP_OKAY));
      rd(OFF_RELOAD, 32'hA5C3_0F96);
      chk(timer_reload, 32'hA5C3_0F96);
   endtask

   // Unused byte bits, single byte lanes and an unmapped address
   task automatic t_prio();
      wr(OFF_PRIO0, 32'hFFFF_FFFF, 4'hF);
      rd(OFF_PRIO0, 32'h1F1F_1F1F);
      wr(OFF_PRIO7, 32'hE7E7_E7E7, 4'h4);
      rd(OFF_PRIO7, 32'h0007_0000);
      wr(8'h40, 32'h0000_0001, 4'hF);
      chk(32'(resp), 32'(RESP_SLVERR));
      rd(8'h40, 32'h0000_0000);
      chk(32'(resp), 32'(RESP_SLVERR));
   endtask

   task automatic t_flag();
      wr(OFF_ENABLE, 32'hFFFF_FFFF, 4'hF);
      rd(OFF_ENABLE, 32'hFFFF_FFFF);
      pulse(32'h8000_0020);
      rd(OFF_FLAG, 32'h8000_0020);
      wr(OFF_FLAG, 32'h8000_0000, 4'hF);
      rd(OFF_FLAG, 32'h8000_0000);
      wr(OFF_FLAG, 32'h0000_0000, 4'hF);
      rd(OFF_FLAG, 32'h0000_0000);
   endtask

   // Selection word is {valid, id, prio, sub}
   task automatic t_select();
      wr(OFF_ENABLE, 32'h0000_0003, 4'hF);
      wr(OFF_PRIO0, 32'h0000_0E0D, 4'hF);
      pulse(32'h0000_0007);
      chk(32'({req_valid, req_id, req_prio, req_sub}), 32'h0000_042E);
      wr(OFF_ENABLE, 32'h0000_0001, 4'hF);
      tick(3);
      chk(32'({req_valid, req_id, req_prio, req_sub}), 32'h0000_040D);
      wr(OFF_PRIO0, 32'h0000_0E01, 4'hF);
      tick(3);
      chk(32'(req_valid), 32'h0000_0000);
      wr(OFF_ENABLE, 32'h0000_0003, 4'hF);
      wr(OFF_PRIO0, 32'h0000_0D1C, 4'hF);
      tick(3);
      chk(32'({req_valid, req_id, req_prio, req_sub}), 32'h0000_041C);
      rd(OFF_SELECT, 32'h8000_0070);
      wr(OFF_FLAG, 32'h0000_0000, 4'hF);
   endtask

   // Reload trigger, event status, masking and clearing of the interrupt
   task automatic t_timer();
      wr(OFF_CTRL, 32'h0000_0001, 4'hF);
      rd(OFF_CTRL, 32'h0000_0001);
      tick(2);
      chk(32'(timer_active), 32'h0000_0001);
      wr(OFF_ENABLE, 32'h0000_0008, 4'hF);
      wr(OFF_EVCLR, 32'h0000_0003, 4'hF);
      wr(OFF_EVEN, 32'h0000_0002, 4'hF);
      load_seen = 0;
      pulse(32'h0000_0008);
      chk(32'(load_seen), 32'h0000_0001);
      rd(OFF_EVSTAT, 32'h0000_0003);
      chk(32'(irq), 32'h0000_0001);
      wr(OFF_EVEN, 32'h0000_0000, 4'hF);
      tick(2);
      chk(32'(irq), 32'h0000_0000);
      wr(OFF_EVEN, 32'h0000_0002, 4'hF);
      wr(OFF_EVCLR, 32'h0000_0003, 4'hF);
      tick(2);
      chk(32'(irq), 32'h0000_0000);
      wr(OFF_CTRL, 32'h0000_0000, 4'hF);
      wr(OFF_FLAG, 32'h0000_0000, 4'hF);
      load_seen = 0;
      pulse(32'h0000_0008);
      chk(32'(load_seen), 32'h0000_0000);
      chk(32'(timer_active), 32'h0000_0000);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog, far beyond the fewer than two hundred cycles the scenarios need
   initial
   begin
      repeat (5000) @(posedge aclk);
      fail_count++;
      stop_test();
   end

   // Reset for 20 cycles, then the scenarios in order
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, fire} <= '0;
      {awaddr, araddr, wdata, wstrb, fire_mask} <= '0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_reload();
      t_prio();
      t_flag();
      t_select();
      t_timer();
      stop_test();
   end
endmodule
`default_nettype wire
